// File: bench/hfr_dev_model.sv
`timescale 1ns/1ps
module hfr_dev_model
	import hfr_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic esc_en,
	input wire logic slow,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid
);
	localparam logic [15:0] apply_pending_changes_cmd = 16'h4143;
	// configured hop limit, value arbitrary
	localparam logic [7:0] DEF_HOPS = 8'h04;
	logic [7:0] fb[64];
	logic [7:0] rb[64];
	logic [7:0] q[$];
	logic [7:0] cur, pend, sum, hops;
	logic unesc, held;
	int idx, rawn, nfr, nbad, plen, ntx;
	task automatic take_frame;
		sum = 8'h00;
		for (int i = 3; i < idx; i++)
			sum = sum + fb[i];
		nfr = nfr + 1;
		plen = idx - 8;
		if (sum != CHK_BASE)
			nbad = nbad + 1;
		else if (fb[3] == FT_TX)
		begin
			ntx = ntx + 1;
			hops = (fb[15] == 8'h00) ? DEF_HOPS : fb[15];
		end
		else if (fb[3] == FT_IMMED || fb[3] == FT_QUEUED)
		begin
			if (fb[3] == FT_IMMED || {fb[5], fb[6]} == apply_pending_changes_cmd)
			begin
				cur = held ? pend : cur;
				held = 1'b0;
			end
			// last value byte only: padded forms read alike
			if (plen > 0 && fb[3] == FT_QUEUED)
			begin
				pend = fb[idx - 2];
				held = 1'b1;
			end
			else if (plen > 0)
				cur = fb[idx - 2];
			if (fb[4] != 8'h00)
			begin
				q = '{8'h00, plen == 0 ? 8'h06 : 8'h05, FT_CMD_RESP, fb[4], fb[5], fb[6], 8'h00};
				if (plen == 0)
					q.push_back(cur);
				sum = 8'h00;
				foreach (q[i])
					sum = sum + ((i > 1) ? q[i] : 8'h00);
				q.push_back(CHK_BASE - sum);
				q.push_front(DELIM);
			end
		end
	endtask
	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			idx = 0;
			rawn = 0;
			nfr = 0;
			nbad = 0;
			ntx = 0;
			hops = 8'h00;
			unesc = 1'b0;
			held = 1'b0;
			cur = 8'h00;
			pend = 8'h00;
			q.delete();
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end
		else
		begin
			tx_ready <= !slow || !tx_ready;
			if (q.size() != 0)
			begin
				rx_data <= q.pop_front();
				rx_valid <= 1'b1;
			end
			else
			begin
				rx_data <= ~rx_data; // idle line never holds a stale byte
				rx_valid <= 1'b0;
			end
			if (tx_valid && tx_ready)
			begin
				if (tx_data == DELIM)
				begin
					idx = 0;
					rawn = 0;
				end
				rb[rawn] = tx_data;
				rawn = rawn + 1;
				if (esc_en && tx_data == ESC)
					unesc = 1'b1;
				else
				begin
					fb[idx] = unesc ? tx_data ^ ESC_XOR : tx_data;
					unesc = 1'b0;
					idx = idx + 1;
					if (idx > 3 && idx == int'({fb[1], fb[2]}) + 4)
						take_frame();
				end
			end
		end
	end
endmodule

// File: bench/hfr_host_asserts.sv
`timescale 1ns/1ps
module hfr_host_asserts
	import hfr_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	AST_TX_HOLD:
	assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte not held");
	AST_RST_IDLE:
	assert property ($rose(rst_n) |-> !tx_valid && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs busy after reset");
	AST_WR_ANSWER:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	AST_RD_ANSWER:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == AXI_OKAY)
		else $error("read not answered");
	AST_B_DONE:
	assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid stuck");
	AST_R_DONE:
	assert property (s_axi_rvalid && s_axi_rready && !s_axi_arvalid |=> !s_axi_rvalid)
		else $error("rvalid stuck");
	AST_AR_BLOCK:
	assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	AST_W_BLOCK:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && s_axi_bresp == AXI_OKAY)
		else $error("write ready while bvalid");
	AST_READY_BACK:
	assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
		else $error("write ready not restored");
endmodule
bind hfr_host hfr_host_asserts u_chk (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data, .tx_valid, .tx_ready);

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import hfr_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, esc = 1'b0, slow = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic tx_valid, tx_ready, rx_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, v;
	logic [7:0] tx_data, rx_data;
	int miscompares = 0, tests_run = 0, cycles = 0;
	logic [7:0] fq[9] = '{8'h7E, 8'h00, 8'h05, 8'h09, 8'h01, 8'h42, 8'h44, 8'h07, 8'h68};
	logic [7:0] ft[28] = '{8'h7E, 8'h00, 8'h16, 8'h10, 8'h01, 8'h00, 8'h7D, 8'h33, 8'hA2, 8'h00,
		8'h40, 8'h0A, 8'h01, 8'h27, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'h54, 8'h78, 8'h44, 8'h61,
		8'h74, 8'h61, 8'h30, 8'h41, 8'h7D, 8'h33};
	logic [7:0] bc[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFE,
		8'h03, 8'h01};
	always #5 clock = ~clock;
	hfr_host #(.MAX_PAYLOAD(8), .OPT_USED_MASK(8'h01)) DUT (.clock, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data, .tx_valid, .tx_ready,
		.rx_data, .rx_valid);
	hfr_dev_model PM (.clock, .rst_n, .esc_en(esc), .slow, .tx_data, .tx_valid, .tx_ready,
		.rx_data, .rx_valid);
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic b;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			b = s_axi_bvalid;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic r;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			r = s_axi_rvalid;
			d = s_axi_rdata;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!r);
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic go(input logic [31:0] c);
		wr(REG_CTRL, c);
		do
			rd(REG_STATUS, v);
		while (v[0] || v[4]);
		// the escaper may still hold the last byte or two
		repeat (6) @(posedge clock);
	endtask
	task automatic cmd(input logic [1:0] k, input logic [7:0] id, input logic [31:0] p,
		input logic [31:0] n);
		wr(REG_FRAME_ID, 32'(id));
		wr(REG_CMD, (k == KIND_IMMED) ? 32'h0000_4143 : 32'h0000_4244);
		wr(REG_PARAM, p);
		wr(REG_PARAM_LEN, n);
		go({29'h0000_0000, k, 1'b1});
		if (id != 8'h00)
		begin
			do
				rd(REG_STATUS, v);
			while (!v[1]);
			wr(REG_STATUS, 32'h0000_0002);
		end
	endtask
	task automatic results;
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			results();
		end
	end
	initial
	begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		rd(REG_STATUS, v);
		chk(v, 32'h0000_0000, "status at reset");
		wr(12'h0FC, 32'hFFFF_FFFF);
		rd(12'h0FC, v);
		chk(v, 32'h0000_0000, "unmapped word");
		cmd(KIND_QUEUED, 8'h01, 32'h0000_0007, 32'h0000_0001);
		for (int i = 0; i < 9; i++)
			chk(32'(PM.fb[i]), 32'(fq[i]), "queued frame");
		rd(REG_RESP_INFO, v);
		chk(v, 32'h0042_4401, "response id and command");
		cmd(KIND_QUEUED, 8'h00, 32'h0000_0007, 32'h0000_0004);
		rd(REG_STATUS, v);
		chk(v, 32'h0000_0000, "silent id zero");
		cmd(KIND_QUEUED, 8'h02, 32'h0000_0000, 32'h0000_0000);
		rd(REG_RESP_DATA, v);
		chk(v, 32'h0000_0000, "value still pending");
		cmd(KIND_IMMED, 8'h03, 32'h0000_0000, 32'h0000_0000);
		cmd(KIND_QUEUED, 8'h04, 32'h0000_0000, 32'h0000_0000);
		rd(REG_RESP_DATA, v);
		chk(v, 32'h0000_0007, "applied value");
		rd(REG_RESP_LEN, v);
		chk(v, 32'h0000_0001, "response length");
		esc <= 1'b1;
		slow <= 1'b1;
		wr(REG_DEST_HI, 32'h0013_A200);
		wr(REG_DEST_LO, 32'h400A_0127);
		wr(REG_FRAME_ID, 32'h0000_0001);
		wr(REG_TXCFG, 32'h0000_0000);
		wr(REG_PAY_LEN, 32'h0000_0008);
		for (int i = 0; i < 8; i++)
			wr(REG_PAYLOAD + 12'(4 * i), 32'(ft[i + 18]));
		go(32'h0000_000D);
		for (int i = 0; i < 28; i++)
			chk(32'(PM.rb[i]), 32'(ft[i]), "escaped frame");
		chk(32'(PM.hops), 32'h0000_0004, "default hop limit");
		wr(REG_PAY_LEN, 32'h0000_0009);
		go(32'h0000_000D);
		rd(REG_STATUS, v);
		chk(v & 32'h0000_0008, 32'h0000_0008, "oversize refused");
		chk(32'(PM.nfr), 32'h0000_0006, "no oversize frame");
		esc <= 1'b0;
		slow <= 1'b0;
		wr(REG_STATUS, 32'h0000_0008);
		wr(REG_PAY_LEN, 32'h0000_0001);
		wr(REG_TXCFG, 32'h0000_FF03);
		go(32'h0000_0015);
		for (int i = 5; i < 17; i++)
			chk(32'(PM.fb[i]), 32'(bc[i - 5]), "broadcast fields");
		chk(32'(PM.hops), 32'h0000_0003, "broadcast radius");
		chk(32'(PM.ntx), 32'h0000_0002, "transmit frames");
		chk(32'(PM.nbad), 32'h0000_0000, "frame checksums");
		results();
	end
endmodule

// File: src/hfr_esc_tx.sv
`timescale 1ns/1ps
module hfr_esc_tx
	import hfr_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic esc_en,
	input wire logic [7:0] in_byte,
	input wire logic in_first,
	input wire logic in_valid,
	output logic in_ready,
	output logic [7:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic pend;
	logic [7:0] pend_byte;
	logic free;

	assign free = !out_valid || out_ready;
	assign in_ready = !pend && free;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			out_valid <= 1'b0;
			out_data <= 8'h00;
			pend <= 1'b0;
			pend_byte <= 8'h00;
		end
		else if (free)
		begin
			if (pend)
			begin
				out_data <= pend_byte;
				out_valid <= 1'b1;
				pend <= 1'b0;
			end
			else if (in_valid)
			begin
				out_valid <= 1'b1;
				// the start delimiter itself is never escaped
				if (esc_en && !in_first && needs_escape(in_byte))
				begin
					out_data <= ESC;
					pend <= 1'b1;
					pend_byte <= in_byte ^ ESC_XOR;
				end
				else
					out_data <= in_byte;
			end
			else
				out_valid <= 1'b0;
		end
	end
endmodule

// File: src/hfr_host.sv
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
//Operation
// - queued parameter request carries frame type 0x09.
// - offset 4 is a correlation id; zero suppresses the response.
// - offsets 5-6 hold ASCII command name, value from offset 7.
// - broadcast uses all-nodes address, unicast the node's 64-bit address.
// - destination at offsets 5-12, most significant byte first.
// - host fills offsets 13-14 with 0xFFFE.
// - options byte at offset 16, unused bits driven to zero.
// - payload from offset 17, no longer than the maximum payload size.
// - checksum is 0xFF minus low byte of sum of body bytes.
// - escaped mode sends 0x7D then byte XOR 0x20.
module hfr_host
	import hfr_pkg::*;
#(
	parameter int MAX_PAYLOAD = 64,
	parameter logic [7:0] OPT_USED_MASK = 8'hFF
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid
);
	localparam int PIW = $clog2(MAX_PAYLOAD);

	typedef enum {S_IDLE, S_DELIM, S_LEN_HI, S_LEN_LO, S_BODY, S_CHK} hfr_state_e;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// axi write side
	logic aw_hold;
	logic w_hold;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	// control and configuration
	hfr_state_e state;
	logic [1:0] kind;
	logic esc_en;
	logic bcast;
	logic start_req;
	logic [7:0] frame_id;
	logic [15:0] cmd_name;
	logic [31:0] param;
	logic [2:0] param_len;
	logic [63:0] dest;
	logic [7:0] radius;
	logic [7:0] options;
	logic [15:0] pay_len;
	logic [7:0] payload_mem [MAX_PAYLOAD];
	logic req_err;
	logic resp_done;
	logic chk_err;
	logic awaiting;
	logic [7:0] wait_id;
	hfr_resp_s resp_q;

	// sequencer
	logic bad_req;
	logic start_ok;
	logic [15:0] body_len;
	logic [15:0] body_cnt;
	logic [15:0] off;
	logic [7:0] sum;
	logic [7:0] body_byte;
	logic [7:0] raw_byte;
	logic raw_valid;
	logic raw_ready;
	logic [2:0] p_sh;
	logic [2:0] d_sh;
	logic [63:0] dest_eff;

	// receive side
	logic resp_stb;
	logic resp_ok;
	hfr_resp_s resp;

	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready = !w_hold && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_bresp = AXI_OKAY;
	assign s_axi_rresp = AXI_OKAY;
	assign do_write = aw_hold && w_hold;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// config is frozen while a frame is on the wire, writes then are dropped
	always_ff @(posedge clock)
	begin
		start_req <= 1'b0;
		if (!rst_n)
		begin
			kind <= KIND_QUEUED;
			esc_en <= 1'b0;
			bcast <= 1'b0;
			frame_id <= 8'h00;
			cmd_name <= 16'h0000;
			param <= 32'h0000_0000;
			param_len <= 3'h0;
			dest <= 64'h0000_0000_0000_0000;
			radius <= 8'h00;
			options <= 8'h00;
			pay_len <= 16'h0000;
		end
		else if (do_write && state == S_IDLE && !start_req)
		begin
			case (aw_addr)
				REG_CTRL:
				begin
					if (w_strb[0])
					begin
						start_req <= w_data[0];
						kind <= w_data[2:1];
						esc_en <= w_data[3];
						bcast <= w_data[4];
					end
				end
				REG_FRAME_ID: frame_id <= 8'(merge(32'(frame_id), w_data, w_strb));
				REG_CMD: cmd_name <= 16'(merge(32'(cmd_name), w_data, w_strb));
				REG_PARAM: param <= merge(param, w_data, w_strb);
				REG_PARAM_LEN: param_len <= 3'(merge(32'(param_len), w_data, w_strb));
				REG_DEST_HI: dest[63:32] <= merge(dest[63:32], w_data, w_strb);
				REG_DEST_LO: dest[31:0] <= merge(dest[31:0], w_data, w_strb);
				REG_TXCFG: {options, radius} <= 16'(merge({16'h0000, options, radius}, w_data,
					w_strb));
				REG_PAY_LEN: pay_len <= 16'(merge(32'(pay_len), w_data, w_strb));
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (do_write && state == S_IDLE && aw_addr[11:8] == REG_PAYLOAD[11:8] && w_strb[0]
			&& 32'(aw_addr[7:2]) < MAX_PAYLOAD)
			payload_mem[PIW'(aw_addr[7:2])] <= w_data[7:0];
	end

	// a payload beyond the device limit or a parameter wider than 4 bytes is refused
	assign bad_req = (kind == KIND_TX) ? (32'(pay_len) > MAX_PAYLOAD)
		: ((kind != KIND_QUEUED && kind != KIND_IMMED) || param_len > PARAM_MAX);
	assign start_ok = start_req && !bad_req;
	assign body_len = (kind == KIND_TX) ? BODY_TX_FIXED + pay_len
		: BODY_CMD_FIXED + 16'(param_len);

	assign off = body_cnt + OFF_BODY;
	assign p_sh = param_len - 3'h1 - 3'(off - OFF_PARAM);
	assign d_sh = 3'h7 - 3'(off - OFF_DEST);
	assign dest_eff = bcast ? BCAST_ADDR : dest;

	always_comb
	begin
		body_byte = 8'h00;
		if (off == OFF_BODY)
			body_byte = (kind == KIND_TX) ? FT_TX : ((kind == KIND_IMMED) ? FT_IMMED
				: FT_QUEUED);
		else if (off == OFF_ID)
			body_byte = frame_id;
		else if (kind != KIND_TX)
		begin
			if (off == OFF_CMD)
				body_byte = cmd_name[15:8];
			else if (off == OFF_CMD + 16'h0001)
				body_byte = cmd_name[7:0];
			else
				body_byte = 8'(param >> {p_sh, 3'b000});
		end
		else if (off < OFF_RSVD)
			body_byte = 8'(dest_eff >> {d_sh, 3'b000});
		else if (off == OFF_RSVD)
			body_byte = TX_RESERVED[15:8];
		else if (off == OFF_RSVD + 16'h0001)
			body_byte = TX_RESERVED[7:0];
		else if (off == OFF_RADIUS)
			body_byte = radius;
		else if (off == OFF_OPTS)
			body_byte = options & OPT_USED_MASK;
		else
			body_byte = payload_mem[PIW'(off - OFF_PAYLOAD)];
	end

	always_comb
	begin
		case (state)
			S_DELIM: raw_byte = DELIM;
			S_LEN_HI: raw_byte = body_len[15:8];
			S_LEN_LO: raw_byte = body_len[7:0];
			S_BODY: raw_byte = body_byte;
			S_CHK: raw_byte = CHK_BASE - sum;
			default: raw_byte = 8'h00;
		endcase
	end
	assign raw_valid = (state != S_IDLE);

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			body_cnt <= 16'h0000;
			sum <= 8'h00;
		end
		else
		begin
			case (state)
				S_IDLE:
				begin
					body_cnt <= 16'h0000;
					sum <= 8'h00;
					if (start_ok)
						state <= S_DELIM;
				end
				S_DELIM: if (raw_ready) state <= S_LEN_HI;
				S_LEN_HI: if (raw_ready) state <= S_LEN_LO;
				S_LEN_LO: if (raw_ready) state <= S_BODY;
				S_BODY:
				begin
					if (raw_ready)
					begin
						sum <= sum + body_byte;
						body_cnt <= body_cnt + 16'h0001;
						if (body_cnt == body_len - 16'h0001)
							state <= S_CHK;
					end
				end
				S_CHK: if (raw_ready) state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	hfr_esc_tx u_esc
	(
		.clock(clock),
		.rst_n(rst_n),
		.esc_en(esc_en),
		.in_byte(raw_byte),
		.in_first(state == S_DELIM),
		.in_valid(raw_valid),
		.in_ready(raw_ready),
		.out_data(tx_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

	hfr_rx_parse u_rx
	(
		.clock(clock),
		.rst_n(rst_n),
		.esc_en(esc_en),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.resp_stb(resp_stb),
		.resp_ok(resp_ok),
		.resp(resp)
	);

	// sticky status, a hardware set in the same cycle as a clear wins
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			req_err <= 1'b0;
			resp_done <= 1'b0;
			chk_err <= 1'b0;
			awaiting <= 1'b0;
			wait_id <= 8'h00;
			resp_q <= '0;
		end
		else
		begin
			if (do_write && aw_addr == REG_STATUS && w_strb[0])
			begin
				if (w_data[1])
					resp_done <= 1'b0;
				if (w_data[2])
					chk_err <= 1'b0;
				if (w_data[3])
					req_err <= 1'b0;
			end
			if (start_req && bad_req)
				req_err <= 1'b1;
			// id zero means the device stays silent, so nothing is awaited
			if (state == S_CHK && raw_ready)
			begin
				awaiting <= (frame_id != 8'h00) && (kind != KIND_TX);
				wait_id <= frame_id;
			end
			if (resp_stb && !resp_ok)
				chk_err <= 1'b1;
			if (resp_stb && resp_ok)
			begin
				resp_q <= resp;
				resp_done <= 1'b1;
				if (resp.frame_id == wait_id)
					awaiting <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
				REG_CTRL: s_axi_rdata <= {27'h0, bcast, esc_en, kind, 1'b0};
				REG_STATUS: s_axi_rdata <= {27'h0, awaiting, req_err, chk_err, resp_done,
					state != S_IDLE};
				REG_FRAME_ID: s_axi_rdata <= {24'h0, frame_id};
				REG_CMD: s_axi_rdata <= {16'h0, cmd_name};
				REG_PARAM: s_axi_rdata <= param;
				REG_PARAM_LEN: s_axi_rdata <= {29'h0, param_len};
				REG_DEST_HI: s_axi_rdata <= dest[63:32];
				REG_DEST_LO: s_axi_rdata <= dest[31:0];
				REG_TXCFG: s_axi_rdata <= {16'h0, options, radius};
				REG_PAY_LEN: s_axi_rdata <= {16'h0, pay_len};
				REG_RESP_INFO: s_axi_rdata <= {resp_q.status, resp_q.cmd, resp_q.frame_id};
				REG_RESP_DATA: s_axi_rdata <= resp_q.data;
				REG_RESP_LEN: s_axi_rdata <= {29'h0, resp_q.data_len};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

// File: src/hfr_pkg.sv
package hfr_pkg;
	// frame type codes
	localparam logic [7:0] FT_IMMED = 8'h08;
	localparam logic [7:0] FT_QUEUED = 8'h09;
	localparam logic [7:0] FT_TX = 8'h10;
	localparam logic [7:0] FT_CMD_RESP = 8'h88;
	// framing and escape bytes
	localparam logic [7:0] DELIM = 8'h7E;
	localparam logic [7:0] ESC = 8'h7D;
	localparam logic [7:0] XON = 8'h11;
	localparam logic [7:0] XOFF = 8'h13;
	localparam logic [7:0] ESC_XOR = 8'h20;
	localparam logic [7:0] CHK_BASE = 8'hFF;
	localparam logic [15:0] TX_RESERVED = 16'hFFFE;
	localparam logic [63:0] BCAST_ADDR = 64'h0000_0000_0000_FFFF;
	// absolute frame offsets
	localparam logic [15:0] OFF_BODY = 16'h0003;
	localparam logic [15:0] OFF_ID = 16'h0004;
	localparam logic [15:0] OFF_CMD = 16'h0005;
	localparam logic [15:0] OFF_PARAM = 16'h0007;
	localparam logic [15:0] OFF_DEST = 16'h0005;
	localparam logic [15:0] OFF_RSVD = 16'h000D;
	localparam logic [15:0] OFF_RADIUS = 16'h000F;
	localparam logic [15:0] OFF_OPTS = 16'h0010;
	localparam logic [15:0] OFF_PAYLOAD = 16'h0011;
	localparam logic [15:0] BODY_CMD_FIXED = 16'h0004;
	localparam logic [15:0] BODY_TX_FIXED = 16'h000E;
	localparam logic [2:0] PARAM_MAX = 3'h4;
	// request kinds held in the control register
	localparam logic [1:0] KIND_QUEUED = 2'h0;
	localparam logic [1:0] KIND_IMMED = 2'h1;
	localparam logic [1:0] KIND_TX = 2'h2;
	// register byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_FRAME_ID = 12'h008;
	localparam logic [11:0] REG_CMD = 12'h00C;
	localparam logic [11:0] REG_PARAM = 12'h010;
	localparam logic [11:0] REG_PARAM_LEN = 12'h014;
	localparam logic [11:0] REG_DEST_HI = 12'h018;
	localparam logic [11:0] REG_DEST_LO = 12'h01C;
	localparam logic [11:0] REG_TXCFG = 12'h020;
	localparam logic [11:0] REG_PAY_LEN = 12'h024;
	localparam logic [11:0] REG_RESP_INFO = 12'h028;
	localparam logic [11:0] REG_RESP_DATA = 12'h02C;
	localparam logic [11:0] REG_RESP_LEN = 12'h030;
	localparam logic [11:0] REG_PAYLOAD = 12'h100;
	localparam logic [1:0] AXI_OKAY = 2'h0;

	typedef struct packed {
		logic [7:0] frame_id;
		logic [15:0] cmd;
		logic [7:0] status;
		logic [31:0] data;
		logic [2:0] data_len;
	} hfr_resp_s;

	function automatic logic needs_escape(input logic [7:0] b);
		return (b == DELIM) || (b == ESC) || (b == XON) || (b == XOFF);
	endfunction
endpackage

// File: src/hfr_rx_parse.sv
`timescale 1ns/1ps
module hfr_rx_parse
	import hfr_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic esc_en,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic resp_stb,
	output logic resp_ok,
	output hfr_resp_s resp
);
	typedef enum {R_HUNT, R_LEN_HI, R_LEN_LO, R_BODY, R_CHK} hfr_rx_e;
	hfr_rx_e state;
	logic esc_pend;
	logic restart;
	logic got;
	logic [7:0] b;
	logic [7:0] ftype;
	logic [7:0] sum;
	logic [15:0] len;
	logic [15:0] idx;

	// in escaped mode a bare delimiter always resynchronises
	assign restart = rx_valid && (rx_data == DELIM) && (esc_en || state == R_HUNT);
	assign got = rx_valid && !restart && !(esc_en && rx_data == ESC);
	assign b = esc_pend ? (rx_data ^ ESC_XOR) : rx_data;

	always_ff @(posedge clock)
	begin
		if (!rst_n || restart)
			esc_pend <= 1'b0;
		else if (rx_valid && esc_en && rx_data == ESC)
			esc_pend <= 1'b1;
		else if (got)
			esc_pend <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		resp_stb <= 1'b0;
		if (!rst_n)
		begin
			state <= R_HUNT;
			resp_ok <= 1'b0;
			resp <= '0;
			ftype <= 8'h00;
			sum <= 8'h00;
			len <= 16'h0000;
			idx <= 16'h0000;
		end
		else if (restart)
			state <= R_LEN_HI;
		else if (got)
		begin
			case (state)
				R_LEN_HI:
				begin
					len[15:8] <= b;
					state <= R_LEN_LO;
				end
				R_LEN_LO:
				begin
					len[7:0] <= b;
					idx <= 16'h0000;
					sum <= 8'h00;
					// bytes of an older response must not leak into this one
					resp.data <= 32'h0000_0000;
					resp.data_len <= 3'h0;
					state <= ({len[15:8], b} == 16'h0000) ? R_HUNT : R_BODY;
				end
				R_BODY:
				begin
					sum <= sum + b;
					idx <= idx + 16'h0001;
					case (idx)
						16'h0000: ftype <= b;
						16'h0001: resp.frame_id <= b;
						16'h0002: resp.cmd[15:8] <= b;
						16'h0003: resp.cmd[7:0] <= b;
						16'h0004: resp.status <= b;
						default:
						begin
							resp.data <= {resp.data[23:0], b};
							if (resp.data_len != PARAM_MAX)
								resp.data_len <= resp.data_len + 3'h1;
						end
					endcase
					if (idx == len - 16'h0001)
						state <= R_CHK;
				end
				R_CHK:
				begin
					resp_stb <= (ftype == FT_CMD_RESP);
					resp_ok <= (8'(sum + b) == CHK_BASE);
					state <= R_HUNT;
				end
				default: state <= R_HUNT;
			endcase
		end
	end
endmodule
